// file: shared/crm_regs.svh
// crm_regs.svh: constants of the chirp/ramp and shift modulator.
// assumes inclusion by bare name; definitions only.
`ifndef CRM_REGS_SVH
`define CRM_REGS_SVH

// -----------------------------------------------------------------------------
// widths
// -----------------------------------------------------------------------------
`define CRM_SEG_CNT      8
`define CRM_SEG_AW       3
`define CRM_LEN_W        16
`define CRM_INC_W        30
`define CRM_DEV_W        33
`define CRM_ACC_W        34
`define CRM_DEN_W        25
`define CRM_RPT_W        16

// -----------------------------------------------------------------------------
// values
// -----------------------------------------------------------------------------
`define CRM_DENOM_RAMP   25'h1000000
`define CRM_SEG_ZERO     3'h0
`define CRM_ADV_LEN      2'h0
`define CRM_ADV_A        2'h1
`define CRM_ADV_B        2'h2
`define CRM_ADV_C        2'h3
`define CRM_SHT_NONE     3'h0
`define CRM_SHT_SOFT     3'h5

`endif

// file: shared/crm_pkg.sv
// crm_pkg: types shared by the modulator and its segment memory.
// assumes crm_regs.svh on the include path.
`default_nettype none
`include "crm_regs.svh"
package crm_pkg;
   typedef struct packed {
      logic [`CRM_LEN_W-1:0]  segmentLength;
      logic                   segmentDoubleCycle;
      logic [`CRM_INC_W-1:0]  segmentIncrement;
      logic [1:0]             segmentAdvanceSource;
      logic [`CRM_SEG_AW-1:0] segmentSuccessor;
      logic                   segmentFastSettle;
      logic                   segmentMarker;
   } crm_seg_t;

   typedef enum logic [1:0] {CRM_IDLE, CRM_RUN, CRM_WAIT, CRM_DONE} crm_state_t;
endpackage : crm_pkg
`default_nettype wire

// file: shared/crm_seg_if.sv
// crm_seg_if: write and read path of the segment table.
// assumes one clock shared by both ends.
`default_nettype none
`include "crm_regs.svh"
interface crm_seg_if import crm_pkg::*;;
   logic                   wrEn;
   logic [`CRM_SEG_AW-1:0] wrAddr;
   crm_seg_t               wrData;
   logic [`CRM_SEG_AW-1:0] rdAddr;
   crm_seg_t               rdData;
   modport mem (input wrEn, wrAddr, wrData, rdAddr, output rdData);
   modport eng (output wrEn, wrAddr, wrData, rdAddr, input rdData);
endinterface : crm_seg_if
`default_nettype wire

// file: verilog/crm_seg_mem.sv
// crm_seg_mem: eight-entry segment table, registered read.
// assumes read address is presented one cycle before data is used.
`default_nettype none
`include "crm_regs.svh"
module crm_seg_mem import crm_pkg::*; (
   input wire logic ref_clk,
   crm_seg_if.mem   seg
);
   crm_seg_t mem [`CRM_SEG_CNT];
   crm_seg_t rdReg;

   // no reset on the table: software loads every segment before enabling
   always_ff @(posedge ref_clk) begin
      if (seg.wrEn) begin
         mem[seg.wrAddr] <= seg.wrData;
      end
      rdReg <= mem[seg.rdAddr];
   end
   assign seg.rdData = rdReg;
endmodule : crm_seg_mem
`default_nettype wire

// file: verilog/crm_modulator.sv
// crm_modulator: ramp segment sequencer plus two-level shift keying.
// assumes ref_clk is the phase detector clock; trigger pins are asynchronous.
`default_nettype none
`include "crm_regs.svh"
module crm_modulator import crm_pkg::*; (
   input  wire logic                          ref_clk,
   input  wire logic                          sys_rst,
   input  wire logic                          rampEnable,
   input  wire logic [`CRM_RPT_W-1:0]         repeatCount,
   input  wire logic                          dividerLsbWrite,
   input  wire logic [`CRM_DEN_W-1:0]         progDenominator,
   input  wire logic                          segWrEn,
   input  wire logic [`CRM_SEG_AW-1:0]        segWrAddr,
   input  wire crm_seg_t                      segWrData,
   input  wire logic [3:0]                    triggerPins,
   input  wire logic [1:0]                    triggerSourceA,
   input  wire logic [1:0]                    triggerSourceB,
   input  wire logic [1:0]                    triggerSourceC,
   input  wire logic [2:0]                    shiftTriggerSelect,
   input  wire logic                          shiftSoftTrigger,
   input  wire logic                          phaseShiftSelect,
   input  wire logic [`CRM_DEV_W-1:0]         shiftDeviation,
   output logic [`CRM_DEN_W-1:0]              denominator,
   output logic signed [`CRM_ACC_W-1:0]       extNumerator,
   output logic                               rampActive,
   output logic [`CRM_SEG_AW-1:0]             segmentIndex,
   output logic                               segmentFastSettle,
   output logic                               segmentMarker,
   output logic                               shiftState
);
   // --------------------------------------------------------------------------
   // trigger pin synchronisers
   // --------------------------------------------------------------------------
   logic [3:0] pinMeta_reg, pinSync_reg, pinPrev_reg;
   logic [3:0] pinRise, pinAny;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pinMeta_reg <= 4'h0;
         pinSync_reg <= 4'h0;
         pinPrev_reg <= 4'h0;
      end else begin
         pinMeta_reg <= triggerPins;
         pinSync_reg <= pinMeta_reg;
         pinPrev_reg <= pinSync_reg;
      end
   end
   assign pinRise = pinSync_reg & ~pinPrev_reg;
   assign pinAny  = pinSync_reg ^ pinPrev_reg;

   function automatic logic srcFire(input logic [1:0] adv, input logic [3:0] rise,
                                    input logic [1:0] a, input logic [1:0] b,
                                    input logic [1:0] c);
      logic f;
      f = 1'b0;
      if (adv == `CRM_ADV_A) begin
         f = rise[a];
      end else if (adv == `CRM_ADV_B) begin
         f = rise[b];
      end else if (adv == `CRM_ADV_C) begin
         f = rise[c];
      end
      return f;
   endfunction : srcFire

   function automatic logic signed [`CRM_ACC_W-1:0] sextDev(input logic [`CRM_DEV_W-1:0] d);
      return {{(`CRM_ACC_W-`CRM_DEV_W){d[`CRM_DEV_W-1]}}, d};
   endfunction : sextDev

   // --------------------------------------------------------------------------
   // segment table
   // --------------------------------------------------------------------------
   crm_seg_if segBus ();
   crm_seg_t  seg;
   crm_state_t state_reg, state_next;
   logic [`CRM_SEG_AW-1:0] segIdx_reg, segIdx_next;

   assign segBus.wrEn   = segWrEn;
   assign segBus.wrAddr = segWrAddr;
   assign segBus.wrData = segWrData;
   // read the upcoming index so data lines up with segIdx_reg
   assign segBus.rdAddr = segIdx_next;
   assign seg           = segBus.rdData;

   crm_seg_mem u_mem (
      .ref_clk (ref_clk),
      .seg     (segBus.mem)
   );

   // --------------------------------------------------------------------------
   // ramp sequencer
   // --------------------------------------------------------------------------
   logic [`CRM_LEN_W-1:0]        elapsed_reg, elapsed_next;
   logic                         half_reg, half_next;
   logic [`CRM_RPT_W-1:0]        pass_reg, pass_next;
   logic signed [`CRM_ACC_W-1:0] acc_reg, acc_next;
   logic tick, lenDone, trigHit, advance, running;

   always_comb begin
      state_next   = state_reg;
      segIdx_next  = segIdx_reg;
      elapsed_next = elapsed_reg;
      half_next    = 1'b0;
      pass_next    = pass_reg;
      acc_next     = acc_reg;
      running      = (state_reg == CRM_RUN);
      tick         = !seg.segmentDoubleCycle || half_reg;
      lenDone      = running && tick &&
                     ({1'b0, elapsed_reg} + 17'h1 >= {1'b0, seg.segmentLength});
      trigHit      = srcFire(seg.segmentAdvanceSource, pinRise,
                             triggerSourceA, triggerSourceB, triggerSourceC);
      advance      = 1'b0;
      if (state_reg == CRM_RUN) begin
         acc_next  = acc_reg + {{(`CRM_ACC_W-`CRM_INC_W){seg.segmentIncrement[`CRM_INC_W-1]}},
                                seg.segmentIncrement};
         half_next = seg.segmentDoubleCycle && !half_reg;
         if (tick) begin
            elapsed_next = elapsed_reg + 16'h1;
         end
         if (seg.segmentAdvanceSource == `CRM_ADV_LEN) begin
            advance = lenDone;
         end else if (trigHit) begin
            advance = 1'b1;
         end else if (lenDone) begin
            state_next = CRM_WAIT;                 // hold end frequency until trigger
         end
      end else if (state_reg == CRM_WAIT) begin
         advance = trigHit;
      end
      if (advance) begin
         segIdx_next  = seg.segmentSuccessor;
         elapsed_next = 16'h0;
         half_next    = 1'b0;
         state_next   = CRM_RUN;
         if (seg.segmentSuccessor == `CRM_SEG_ZERO && repeatCount != 16'h0) begin
            pass_next = pass_reg + 16'h1;
            if (pass_reg + 16'h1 == repeatCount) begin
               state_next  = CRM_DONE;
               segIdx_next = segIdx_reg;
            end
         end
      end
      if (!rampEnable) begin
         state_next   = CRM_IDLE;
         segIdx_next  = `CRM_SEG_ZERO;
         elapsed_next = 16'h0;
         pass_next    = 16'h0;
         acc_next     = '0;
      end else if (dividerLsbWrite) begin
         state_next   = CRM_RUN;
         segIdx_next  = `CRM_SEG_ZERO;
         elapsed_next = 16'h0;
         half_next    = 1'b0;
         pass_next    = 16'h0;
         acc_next     = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_reg   <= CRM_IDLE;
         segIdx_reg  <= `CRM_SEG_ZERO;
         elapsed_reg <= 16'h0;
         half_reg    <= 1'b0;
         pass_reg    <= 16'h0;
         acc_reg     <= '0;
      end else begin
         state_reg   <= state_next;
         segIdx_reg  <= segIdx_next;
         elapsed_reg <= elapsed_next;
         half_reg    <= half_next;
         pass_reg    <= pass_next;
         acc_reg     <= acc_next;
      end
   end

   // --------------------------------------------------------------------------
   // shift keying and output numerator
   // --------------------------------------------------------------------------
   logic shift_reg, shift_next, shiftFire;
   logic signed [`CRM_ACC_W-1:0] shiftTerm, num_next, num_reg;
   logic [`CRM_DEN_W-1:0] den_next, den_reg;
   logic fast_reg, fast_next, mark_reg, mark_next;

   always_comb begin
      shiftFire = 1'b0;
      if (shiftTriggerSelect == `CRM_SHT_SOFT) begin
         shiftFire = shiftSoftTrigger;
      end else if (shiftTriggerSelect != `CRM_SHT_NONE && shiftTriggerSelect < `CRM_SHT_SOFT) begin
         shiftFire = pinAny[2'(shiftTriggerSelect - 3'h1)];
      end
      shift_next = shift_reg ^ shiftFire;
      shiftTerm  = '0;
      if (!phaseShiftSelect) begin
         shiftTerm = shift_next ? sextDev(shiftDeviation) : '0;
      end else if (shiftFire) begin
         // phase step: numerator offset for a single cycle moves phase by dev/denominator (2^24 unless idle)
         shiftTerm = shift_next ? sextDev(shiftDeviation) : -sextDev(shiftDeviation);
      end
      num_next  = acc_next + shiftTerm;
      den_next  = (state_next != CRM_IDLE) ? `CRM_DENOM_RAMP : progDenominator;
      fast_next = (state_next == CRM_RUN || state_next == CRM_WAIT) &&
                  segBus.rdData.segmentFastSettle && (segIdx_next == segIdx_reg);
      mark_next = (state_next == CRM_RUN || state_next == CRM_WAIT) &&
                  segBus.rdData.segmentMarker && (segIdx_next == segIdx_reg);
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         shift_reg <= 1'b0;
         num_reg   <= '0;
         den_reg   <= `CRM_DENOM_RAMP;
         fast_reg  <= 1'b0;
         mark_reg  <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         num_reg   <= num_next;
         den_reg   <= den_next;
         fast_reg  <= fast_next;
         mark_reg  <= mark_next;
      end
   end

   assign extNumerator      = num_reg;
   assign denominator       = den_reg;
   assign shiftState        = shift_reg;
   assign segmentIndex      = segIdx_reg;
   assign rampActive        = (state_reg == CRM_RUN) || (state_reg == CRM_WAIT);
   assign segmentFastSettle = fast_reg;
   assign segmentMarker     = mark_reg;

   // --------------------------------------------------------------------------
   // checks
   // --------------------------------------------------------------------------
   chk_denom_forced: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_reg != CRM_IDLE) |-> denominator == `CRM_DENOM_RAMP)
      else $error("denominator not forced while ramping");
   chk_restart_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (rampEnable && dividerLsbWrite) |=> (segmentIndex == `CRM_SEG_ZERO && state_reg == CRM_RUN))
      else $error("restart did not return to segment zero");
   chk_slope_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_reg == CRM_RUN && rampEnable && !dividerLsbWrite) |=>
      acc_reg == $past(acc_reg) + $signed($past(seg.segmentIncrement)))
      else $error("numerator slope step wrong");
   chk_length_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (running && !seg.segmentDoubleCycle && seg.segmentLength == 16'h3 &&
       seg.segmentAdvanceSource == `CRM_ADV_LEN && elapsed_reg == 16'h0 &&
       rampEnable && !dividerLsbWrite) ##1 (rampEnable && !dividerLsbWrite)[*2]
      |-> ##1 elapsed_reg == 16'h0)
      else $error("segment length not honoured");
   chk_wait_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_reg == CRM_WAIT && !advance && rampEnable && !dividerLsbWrite) |=>
      $stable(acc_reg) && $stable(segmentIndex))
      else $error("waiting segment moved");
   chk_enable_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !rampEnable |=> (state_reg == CRM_IDLE && !rampActive && acc_reg == '0))
      else $error("ramp kept running after disable");
   chk_shift_toggle: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (shiftTriggerSelect == `CRM_SHT_SOFT && shiftSoftTrigger) |=> shiftState != $past(shiftState))
      else $error("software shift trigger ignored");
   chk_fsk_sum: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!phaseShiftSelect && shift_next) |=> extNumerator == acc_reg + sextDev($past(shiftDeviation)))
      else $error("shift deviation not summed with ramp");
   chk_pin_latency: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (shiftTriggerSelect == 3'h1 && $rose(pinSync_reg[0])) |=> shiftState != $past(shiftState))
      else $error("pin transition did not toggle shift");
endmodule : crm_modulator
`default_nettype wire

// file: test/crm_pin_model.sv
// crm_pin_model: external equipment driving the four trigger pins.
// assumes pins idle low; edges land at odd times, unrelated to ref_clk.
`default_nettype none
module crm_pin_model (
   output var logic [3:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pins = 4'h0;
   // offset keeps pin edges off the clock edge, as a real async source would
   task automatic set_pin(input int idx, input logic val);
      #3;
      pins[idx] = val;
   endtask : set_pin
endmodule : crm_pin_model
`default_nettype wire

// file: test/testbench.sv
// testbench: self-checking bench of the ramp sequencer and shift keying.
// assumes crm_regs.svh on the include path; pins come from crm_pin_model.
`default_nettype none
`include "crm_regs.svh"
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin \
   num_errors++; $display("MISMATCH %0t %s", $time, msg); end end
module testbench import crm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic                    ref_clk, sys_rst, rampEnable, dividerLsbWrite, segWrEn;
   logic [15:0]             repeatCount;
   logic [24:0]             progDenominator, denominator;
   logic [2:0]              segWrAddr, shiftTriggerSelect, segmentIndex;
   crm_seg_t                segWrData;
   logic [3:0]              triggerPins;
   logic [1:0]              triggerSourceA, triggerSourceB, triggerSourceC;
   logic                    shiftSoftTrigger, phaseShiftSelect, rampActive;
   logic                    segmentFastSettle, segmentMarker, shiftState;
   logic [32:0]             shiftDeviation;
   logic signed [33:0]      extNumerator, dev;
   logic [31:0]             r;
   int                      num_errors = 0;
   int                      total_checks = 0;
   int                      seed = 39482;

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   crm_pin_model i_pins (.pins(triggerPins));
   crm_modulator i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .rampEnable(rampEnable),
      .repeatCount(repeatCount), .dividerLsbWrite(dividerLsbWrite),
      .progDenominator(progDenominator), .segWrEn(segWrEn), .segWrAddr(segWrAddr),
      .segWrData(segWrData), .triggerPins(triggerPins), .triggerSourceA(triggerSourceA),
      .triggerSourceB(triggerSourceB), .triggerSourceC(triggerSourceC),
      .shiftTriggerSelect(shiftTriggerSelect), .shiftSoftTrigger(shiftSoftTrigger),
      .phaseShiftSelect(phaseShiftSelect), .shiftDeviation(shiftDeviation),
      .denominator(denominator), .extNumerator(extNumerator), .rampActive(rampActive),
      .segmentIndex(segmentIndex), .segmentFastSettle(segmentFastSettle),
      .segmentMarker(segmentMarker), .shiftState(shiftState));

   // ---------------------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------------------
   task automatic tick(input int n = 1);
      repeat (n) @(negedge ref_clk);
   endtask : tick

   function automatic crm_seg_t mkseg(input logic [15:0] len, input logic dbl,
                                      input logic [29:0] inc, input logic [1:0] src,
                                      input logic [2:0] nxt, input logic fs, mk);
      return '{len, dbl, inc, src, nxt, fs, mk};
   endfunction : mkseg

   // caller drops segWrEn, so back-to-back writes keep it high
   task automatic wr(input logic [2:0] a, input crm_seg_t d);
      segWrEn = 1'b1;
      segWrAddr = a;
      segWrData = d;
      tick();
   endtask : wr

   // leaves us at the first cycle of segment zero
   task automatic restart();
      dividerLsbWrite = 1'b1;
      tick();
      dividerLsbWrite = 1'b0;
   endtask : restart

   task automatic walk(input crm_seg_t d, input logic signed [33:0] base);
      int n;
      logic signed [33:0] inc;
      n = (d.segmentLength == 16'h0 ? 1 : int'(d.segmentLength)) * (d.segmentDoubleCycle ? 2 : 1);
      inc = $signed({{4{d.segmentIncrement[29]}}, d.segmentIncrement});
      wr(3'h0, d);
      segWrEn = 1'b0;
      restart();
      for (int k = 0; k <= n; k++) begin
         `CHK(extNumerator, base + inc * k, "ramp numerator")
         `CHK(segmentIndex, (k < n) ? 3'h0 : 3'h1, "segment length")
         `CHK(denominator, `CRM_DENOM_RAMP, "forced denominator")
         if (k == 1 && n >= 3) begin
            `CHK(segmentMarker, d.segmentMarker, "marker")
            `CHK(segmentFastSettle, d.segmentFastSettle, "fast settle")
         end
         tick();
      end
   endtask : walk

   task automatic flip(input logic lvl);
      for (int i = 0; i < 8 && shiftState !== lvl; i++) tick();
      `CHK(shiftState, lvl, "shift level")
   endtask : flip

   task automatic psk(input logic lvl, input logic signed [33:0] e);
      int hits;
      hits = 0;
      shiftSoftTrigger = 1'b1;
      tick();
      shiftSoftTrigger = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (extNumerator === e) hits++;
         tick();
      end
      `CHK(hits, 1, "phase impulse width")
      `CHK(shiftState, lvl, "phase level")
      `CHK(extNumerator, 34'sh0, "phase impulse end")
   endtask : psk

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict

   // ---------------------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------------------
   initial begin
      #200us;
      num_errors++;
      give_verdict();
   end

   initial begin
      {rampEnable, dividerLsbWrite, segWrEn, shiftSoftTrigger, phaseShiftSelect} = '0;
      sys_rst = 1'b1;
      repeatCount = 16'h0;
      r = $random(seed);
      progDenominator = r[24:0];
      segWrAddr = 3'h0;
      segWrData = '0;
      triggerSourceA = 2'h3;
      triggerSourceB = 2'h0;
      triggerSourceC = 2'h1;
      shiftTriggerSelect = 3'h0;
      shiftDeviation = 33'h0;
      tick(5);
      sys_rst = 1'b0;
      tick(2);
      `CHK(denominator, progDenominator, "idle denominator")
      `CHK(extNumerator, 34'sh0, "idle numerator")
      rampEnable = 1'b1;
      wr(3'h1, mkseg(16'hFFFF, 1'b0, 30'h0, 2'h0, 3'h1, 1'b0, 1'b0));
      walk(mkseg(16'h3, 1'b0, 30'h5, 2'h0, 3'h1, 1'b1, 1'b0), 34'sh0);
      walk(mkseg(16'h0, 1'b1, 30'h3FFFFFFF, 2'h0, 3'h1, 1'b0, 1'b1), 34'sh0);
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         walk(mkseg(16'(r % 6), r[31], 30'($random(seed)), 2'h0, 3'h1, r[5], r[9]), 34'sh0);
      end
      $display("test walk done");
      for (int i = 0; i < 8; i++) wr(3'(i), mkseg(16'h1, 1'b0, 30'(i + 1), 2'h0, 3'(i + 1), 1'b0, 1'b0));
      segWrEn = 1'b0;
      restart();
      for (int k = 0, s = 0; k < 18; k++) begin
         `CHK(segmentIndex, 3'(k % 8), "chain order")
         `CHK(extNumerator, 34'(s), "chain numerator")
         s += k % 8 + 1;
         tick();
      end
      $display("test chain done");
      for (int s = 1; s < 4; s++) begin
         wr(3'h0, mkseg(16'h2, 1'b0, 30'h1, 2'(s), 3'h1, 1'b0, 1'b0));
         segWrEn = 1'b0;
         restart();
         tick(6);
         `CHK(segmentIndex, 3'h0, "waits for trigger")
         `CHK(extNumerator, 34'sh2, "held in wait")
         i_pins.set_pin(2, 1'b1);
         tick(6);
         `CHK(segmentIndex, 3'h0, "unselected pin ignored")
         i_pins.set_pin(2, 1'b0);
         i_pins.set_pin(s == 1 ? 3 : s - 2, 1'b1);
         for (int i = 0; i < 8 && segmentIndex !== 3'h1; i++) tick();
         `CHK(segmentIndex, 3'h1, "trigger advance")
         i_pins.set_pin(s == 1 ? 3 : s - 2, 1'b0);
         tick(2);
      end
      $display("test trigger done");
      wr(3'h0, mkseg(16'h1, 1'b0, 30'h7, 2'h0, 3'h0, 1'b0, 1'b0));
      segWrEn = 1'b0;
      repeatCount = 16'h3;
      restart();
      for (int i = 0; i < 20 && rampActive !== 1'b0; i++) tick();
      `CHK(rampActive, 1'b0, "repeat count stop")
      `CHK(extNumerator, 34'sh15, "repeat end value")
      dev = extNumerator;
      tick(3);
      `CHK(extNumerator, dev, "done holds")
      `CHK(denominator, `CRM_DENOM_RAMP, "done denominator")
      repeatCount = 16'h0;
      restart();
      tick(30);
      `CHK(rampActive, 1'b1, "loops forever")
      rampEnable = 1'b0;
      tick(3);
      `CHK(rampActive, 1'b0, "disable stops")
      `CHK(denominator, progDenominator, "idle denominator")
      $display("test repeat done");
      shiftDeviation = 33'($random(seed)) | 33'h1;
      dev = $signed({shiftDeviation[32], shiftDeviation});
      shiftSoftTrigger = 1'b1;
      tick();
      shiftSoftTrigger = 1'b0;
      tick(6);
      `CHK(shiftState, 1'b0, "no shift source")
      shiftTriggerSelect = `CRM_SHT_SOFT;
      shiftSoftTrigger = 1'b1;
      tick();
      shiftSoftTrigger = 1'b0;
      flip(1'b1);
      `CHK(extNumerator, dev, "frequency shift")
      rampEnable = 1'b1;
      walk(mkseg(16'h4, 1'b0, 30'h9, 2'h0, 3'h1, 1'b0, 1'b0), dev);
      rampEnable = 1'b0;
      for (int sel = 1; sel < 5; sel++) begin
         shiftTriggerSelect = 3'(sel);
         i_pins.set_pin(sel - 1, 1'b1);
         flip(1'b0);
         i_pins.set_pin(sel - 1, 1'b0);
         flip(1'b1);
         `CHK(extNumerator, dev, "pin shift level")
      end
      phaseShiftSelect = 1'b1;
      shiftTriggerSelect = `CRM_SHT_SOFT;
      tick(2);
      psk(1'b0, -dev);
      psk(1'b1, dev);
      $display("test shift done");
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
